/* src/lg_pkg.sv */
package lg_pkg;

  // ----------------------------------------------------------------
  // Sizes of one logic group
  // ----------------------------------------------------------------
  localparam int NUM_MC = 16;
  localparam int NUM_IN = 40;
  localparam int NUM_PT = 56;
  localparam int NUM_EXT = 32;
  localparam int NUM_GCK = 3;
  localparam int NUM_GTS = 2;
  // The selectable pool is the outside routing, the pins, the macrocell feedback and the buried nodes.
  localparam int POOL = NUM_EXT + 3 * NUM_MC;
  localparam int SEL_W = 7;
  localparam int PT_IDX_W = 6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic MC_STATE_RST = 1'h0;
  localparam logic CK_PREV_RST = 1'h0;
  localparam logic PAD_OUT_RST = 1'h0;
  localparam logic PAD_OE_N_RST = 1'h1;
  localparam logic SYNC_RST = 1'h0;

  // ----------------------------------------------------------------
  // Configuration encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {MODE_COMB, MODE_DFF, MODE_TFF, MODE_LATCH} lg_mode_t;
  typedef enum logic [2:0] {CLK_GCK0, CLK_GCK1, CLK_GCK2, CLK_GROUP, CLK_LOCAL} lg_clk_src_t;
  typedef enum logic [1:0] {SR_NONE, SR_GLOBAL, SR_GROUP, SR_LOCAL} lg_sr_src_t;
  typedef enum logic [2:0] {OE_ALWAYS, OE_GTS0, OE_GTS1, OE_GROUP, OE_LOCAL} lg_oe_src_t;
  typedef enum logic [1:0] {PAD_PUSH, PAD_TRI, PAD_OD} lg_pad_mode_t;
  typedef logic [PT_IDX_W-1:0] lg_pt_idx_t;

  // Global pins shared by every group.
  typedef struct packed {
    logic [NUM_GCK-1:0] gck;
    logic gsr;
    logic [NUM_GTS-1:0] gts;
  } lg_glob_t;

  // Product-term indices of the shared control terms.
  typedef struct packed {
    lg_pt_idx_t ct_clk_pt;
    lg_pt_idx_t ct_set_pt;
    lg_pt_idx_t ct_rst_pt;
    lg_pt_idx_t ct_oe_pt;
  } lg_grp_cfg_t;

  // Per-macrocell configuration.
  typedef struct packed {
    lg_mode_t mode;
    logic input_reg;
    logic xor_en;
    lg_pt_idx_t xor_pt;
    logic invert;
    lg_clk_src_t clk_src;
    logic clk_fall;
    logic both_edge;
    logic ce_en;
    lg_pt_idx_t ce_pt;
    lg_pt_idx_t clk_pt;
    lg_sr_src_t set_src;
    lg_pt_idx_t set_pt;
    lg_sr_src_t rst_src;
    lg_pt_idx_t rst_pt;
    lg_oe_src_t oe_src;
    lg_pt_idx_t oe_pt;
    lg_pad_mode_t pad_mode;
  } lg_mc_cfg_t;

endpackage : lg_pkg

/* src/lg_macrocell.sv */
`timescale 1ns/1ps

module lg_macrocell
  import lg_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Configuration.
  input wire lg_mc_cfg_t cfg,
  // Data and controls already selected by the group.
  input wire logic logic_in,
  input wire logic pin_in,
  input wire logic ck_lvl,
  input wire logic set_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Results.
  output logic state_q,
  output logic mc_val
);

  logic ck_prev_q;
  logic din;
  logic edge_hit;
  logic latch_open;
  logic state_d;

  // ----------------------------------------------------------------
  // Clock edge detection
  // ----------------------------------------------------------------
  // The macrocell clock is a sampled level, so an edge is a change between two samples.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ck_prev_q <= CK_PREV_RST;
    end else begin
      ck_prev_q <= ck_lvl;
    end
  end

  always_comb begin
    if (cfg.both_edge) begin
      edge_hit = ck_lvl ^ ck_prev_q;
    end else if (cfg.clk_fall) begin
      edge_hit = !ck_lvl && ck_prev_q;
    end else begin
      edge_hit = ck_lvl && !ck_prev_q;
    end
    // A latch follows while the clock sits at its selected active level.
    latch_open = ck_lvl ^ cfg.clk_fall;
  end

  // ----------------------------------------------------------------
  // Storage element
  // ----------------------------------------------------------------
  // input register source.
  assign din = cfg.input_reg ? pin_in : logic_in;

  // Reset beats set, and both beat the clock, the enable and the mode.
  always_comb begin
    state_d = state_q;
    if (rst_in) begin
      state_d = 1'h0;
    end else if (set_in) begin
      state_d = 1'h1;
    end else begin
      case (cfg.mode)
        MODE_DFF: begin
          if (edge_hit && ce_in) begin
            state_d = din;
          end
        end
        MODE_TFF: begin
          if (edge_hit && din) begin
            state_d = !state_q;
          end
        end
        MODE_LATCH: begin
          if (latch_open) begin
            state_d = din;
          end
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q <= MC_STATE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  assign mc_val = (cfg.mode == MODE_COMB && !cfg.input_reg) ? logic_in : state_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb_mc @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_quiet_tff_edge;
    cfg.mode == MODE_TFF && edge_hit && !set_in && !rst_in;
  endsequence

  a_reset_wins: assert property (rst_in |=> !state_q)
    else $error("reset did not clear the storage element");
  a_set_applies: assert property (set_in && !rst_in |=> state_q)
    else $error("set did not raise the storage element");
  a_tff_toggle: assert property (s_quiet_tff_edge ##0 din |=> state_q != $past(state_q))
    else $error("toggle flop did not invert");
  a_tff_hold: assert property (s_quiet_tff_edge ##0 !din |=> $stable(state_q))
    else $error("toggle flop changed with low input");
  a_dff_ce_hold: assert property (cfg.mode == MODE_DFF && !ce_in && !set_in && !rst_in |=> $stable(state_q))
    else $error("disabled D flop changed state");
  a_dff_capture: assert property (cfg.mode == MODE_DFF && edge_hit && ce_in && !set_in && !rst_in
                                  |=> state_q == $past(din))
    else $error("D flop missed its data");

endmodule : lg_macrocell

/* src/lg_logic_group.sv */
`timescale 1ns/1ps

module lg_logic_group
  import lg_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Pins owned by this group's macrocells.
  input wire logic [NUM_MC-1:0] pin_in,
  output logic [NUM_MC-1:0] pin_out_q,
  output logic [NUM_MC-1:0] pin_oe_n_q,
  // Global clock, set/reset and output-enable pins.
  input wire lg_glob_t glob_pins,
  // Routing matrix traffic to and from the other groups.
  input wire logic [NUM_EXT-1:0] route_ext,
  output logic [NUM_MC-1:0] route_mc_q,
  output logic [NUM_MC-1:0] route_node_q,
  output logic [NUM_MC-1:0] route_pin_q,
  // Static configuration.
  input wire logic [NUM_IN-1:0][SEL_W-1:0] route_sel,
  input wire logic [NUM_PT-1:0][NUM_IN-1:0] and_true,
  input wire logic [NUM_PT-1:0][NUM_IN-1:0] and_comp,
  input wire logic [NUM_MC-1:0][NUM_PT-1:0] or_sel,
  input wire lg_grp_cfg_t grp_cfg,
  input wire lg_mc_cfg_t [NUM_MC-1:0] mc_cfg
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // An index past the last product term reads as a constant low term.
  function automatic logic pt_pick(input logic [NUM_PT-1:0] pts, input lg_pt_idx_t idx);
    logic res;
    res = 1'h0;
    if (idx < PT_IDX_W'(NUM_PT)) begin
      res = pts[idx];
    end
    return res;
  endfunction : pt_pick

  // Set and reset share one source choice encoding.
  function automatic logic sr_pick(input lg_sr_src_t src, input logic glob, input logic grp, input logic loc);
    logic res;
    res = 1'h0;
    case (src)
      SR_GLOBAL: res = glob;
      SR_GROUP: res = grp;
      SR_LOCAL: res = loc;
      default: res = 1'h0;
    endcase
    return res;
  endfunction : sr_pick

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [NUM_MC-1:0] pin_s1_q;
  logic [NUM_MC-1:0] pin_s2_q;
  lg_glob_t glob_s1_q;
  lg_glob_t glob_s2_q;

  // Pins arrive asynchronously, so only the second stage is looked at by logic.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_s1_q <= {NUM_MC{SYNC_RST}};
      pin_s2_q <= {NUM_MC{SYNC_RST}};
      glob_s1_q <= '0;
      glob_s2_q <= '0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      glob_s1_q <= glob_pins;
      glob_s2_q <= glob_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Routing matrix input selection
  // ----------------------------------------------------------------
  logic [POOL-1:0] pool;
  logic [NUM_IN-1:0] grp_in;

  assign pool = {route_node_q, route_mc_q, route_pin_q, route_ext};

  always_comb begin
    for (int i = 0; i < NUM_IN; i++) begin
      grp_in[i] = (route_sel[i] < SEL_W'(POOL)) ? pool[route_sel[i]] : 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // Product-term array
  // ----------------------------------------------------------------
  logic [NUM_PT-1:0] pterm;

  // AND array terms.
  // A term with no literal connected is unused and reads low, not as a constant one.
  always_comb begin
    for (int p = 0; p < NUM_PT; p++) begin
      pterm[p] = ((and_true[p] | and_comp[p]) != '0) &&
                 ((~grp_in & and_true[p]) == '0) &&
                 ((grp_in & and_comp[p]) == '0);
    end
  end

  // ----------------------------------------------------------------
  // Shared control terms
  // ----------------------------------------------------------------
  logic ct_clk;
  logic ct_set;
  logic ct_rst;
  logic ct_oe;

  assign ct_clk = pt_pick(pterm, grp_cfg.ct_clk_pt);
  assign ct_set = pt_pick(pterm, grp_cfg.ct_set_pt);
  assign ct_rst = pt_pick(pterm, grp_cfg.ct_rst_pt);
  assign ct_oe = pt_pick(pterm, grp_cfg.ct_oe_pt);

  // ----------------------------------------------------------------
  // Per-macrocell logic and control selection
  // ----------------------------------------------------------------
  logic [NUM_MC-1:0] sop;
  logic [NUM_MC-1:0] mc_logic;
  logic [NUM_MC-1:0] mc_ck;
  logic [NUM_MC-1:0] mc_set;
  logic [NUM_MC-1:0] mc_rst;
  logic [NUM_MC-1:0] mc_ce;
  logic [NUM_MC-1:0] mc_oe;
  logic [NUM_MC-1:0] mc_state;
  logic [NUM_MC-1:0] mc_val;

  // shared OR array.
  // Every macrocell masks the full term vector, so a term costs nothing extra when reused.
  always_comb begin
    for (int m = 0; m < NUM_MC; m++) begin
      sop[m] = |(pterm & or_sel[m]);
      mc_logic[m] = sop[m] ^ (mc_cfg[m].xor_en & pt_pick(pterm, mc_cfg[m].xor_pt)) ^ mc_cfg[m].invert;
    end
  end

  always_comb begin
    for (int m = 0; m < NUM_MC; m++) begin
      case (mc_cfg[m].clk_src)
        CLK_GCK0: mc_ck[m] = glob_s2_q.gck[0];
        CLK_GCK1: mc_ck[m] = glob_s2_q.gck[1];
        CLK_GCK2: mc_ck[m] = glob_s2_q.gck[2];
        CLK_GROUP: mc_ck[m] = ct_clk;
        CLK_LOCAL: mc_ck[m] = pt_pick(pterm, mc_cfg[m].clk_pt);
        default: mc_ck[m] = 1'h0;
      endcase
      mc_set[m] = sr_pick(mc_cfg[m].set_src, glob_s2_q.gsr, ct_set, pt_pick(pterm, mc_cfg[m].set_pt));
      mc_rst[m] = sr_pick(mc_cfg[m].rst_src, glob_s2_q.gsr, ct_rst, pt_pick(pterm, mc_cfg[m].rst_pt));
      mc_ce[m] = !mc_cfg[m].ce_en || pt_pick(pterm, mc_cfg[m].ce_pt);
      case (mc_cfg[m].oe_src)
        OE_ALWAYS: mc_oe[m] = 1'h1;
        OE_GTS0: mc_oe[m] = glob_s2_q.gts[0];
        OE_GTS1: mc_oe[m] = glob_s2_q.gts[1];
        OE_GROUP: mc_oe[m] = ct_oe;
        OE_LOCAL: mc_oe[m] = pt_pick(pterm, mc_cfg[m].oe_pt);
        default: mc_oe[m] = 1'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Macrocell storage
  // ----------------------------------------------------------------
  // sixteen macrocells.
  for (genvar g = 0; g < NUM_MC; g++) begin : g_mc
    lg_macrocell u_mc (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .cfg(mc_cfg[g]),
      .logic_in(mc_logic[g]),
      .pin_in(pin_s2_q[g]),
      .ck_lvl(mc_ck[g]),
      .set_in(mc_set[g]),
      .rst_in(mc_rst[g]),
      .ce_in(mc_ce[g]),
      .state_q(mc_state[g]),
      .mc_val(mc_val[g])
    );
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  logic [NUM_MC-1:0] pad_out_d;
  logic [NUM_MC-1:0] pad_oe_n_d;

  always_comb begin
    for (int m = 0; m < NUM_MC; m++) begin
      pad_out_d[m] = mc_val[m];
      pad_oe_n_d[m] = 1'h0;
      if (mc_cfg[m].input_reg) begin
        pad_out_d[m] = 1'h0;
        pad_oe_n_d[m] = 1'h1;
      end else begin
        case (mc_cfg[m].pad_mode)
          PAD_PUSH: pad_oe_n_d[m] = 1'h0;
          PAD_TRI: pad_oe_n_d[m] = !mc_oe[m];
          PAD_OD: begin
            // Open drain never drives high; the released pin is pulled up outside.
            pad_out_d[m] = 1'h0;
            pad_oe_n_d[m] = !(mc_oe[m] && !mc_val[m]);
          end
          default: pad_oe_n_d[m] = 1'h1;
        endcase
      end
    end
  end

  // Registering every output costs one cycle but keeps pins and feedback glitch free.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pin_out_q <= {NUM_MC{PAD_OUT_RST}};
      pin_oe_n_q <= {NUM_MC{PAD_OE_N_RST}};
    end else begin
      pin_out_q <= pad_out_d;
      pin_oe_n_q <= pad_oe_n_d;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      route_mc_q <= {NUM_MC{MC_STATE_RST}};
      route_node_q <= {NUM_MC{MC_STATE_RST}};
      route_pin_q <= {NUM_MC{SYNC_RST}};
    end else begin
      route_mc_q <= mc_val;
      route_node_q <= mc_logic;
      route_pin_q <= pin_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb_grp @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_pin_high_held;
    pin_in[0] [*4];
  endsequence

  sequence s_od_high_out;
    mc_cfg[2].pad_mode == PAD_OD && !mc_cfg[2].input_reg && mc_val[2];
  endsequence

  a_pin_feedback: assert property (s_pin_high_held |=> route_pin_q[0])
    else $error("pin level did not reach the routing feedback");
  a_od_release: assert property (s_od_high_out |=> pin_oe_n_q[2] && !pin_out_q[2])
    else $error("open drain pin was driven high");
  a_input_reg_free: assert property (mc_cfg[6].input_reg |=> pin_oe_n_q[6])
    else $error("input register pin was driven");
  a_node_follows: assert property (mc_cfg[6].input_reg && mc_cfg[6].xor_en == 1'h0
                                   |=> route_node_q[6] == ($past(sop[6]) ^ $past(mc_cfg[6].invert)))
    else $error("buried node lost its logic value");

  // A three-state pin whose enable is low must let go of the line.
  sequence s_tri_off;
    mc_cfg[0].pad_mode == PAD_TRI && !mc_cfg[0].input_reg && !mc_oe[0];
  endsequence

  a_tri_release: assert property (s_tri_off |=> pin_oe_n_q[0])
    else $error("three-state pin drove without its enable");
  a_push_drive: assert property (mc_cfg[1].pad_mode == PAD_PUSH && !mc_cfg[1].input_reg
                                 |=> !pin_oe_n_q[1] && pin_out_q[1] == $past(mc_val[1]))
    else $error("push-pull pin did not drive its value");
  a_comb_path: assert property (mc_cfg[0].mode == MODE_COMB && !mc_cfg[0].input_reg
                                |=> route_mc_q[0] == $past(mc_logic[0]))
    else $error("combinational output lost its logic value");

endmodule : lg_logic_group

/* bench/lg_pin_model.sv */
`timescale 1ns/1ps

module lg_pin_model
  import lg_pkg::*;
(
  // Pad side of the logic group.
  input wire logic [NUM_MC-1:0] pin_out_q,
  input wire logic [NUM_MC-1:0] pin_oe_n_q,
  // Board drivers that the bench controls.
  input wire logic [NUM_MC-1:0] ext_en,
  input wire logic [NUM_MC-1:0] ext_val,
  // Pad level fed back to the group.
  output logic [NUM_MC-1:0] pad
);
  // ----------------------------------------------------------------
  // Pad resolution
  // ----------------------------------------------------------------
  // A released pad with no board driver enabled floats up to the board pull-up, since open-drain use relies on it.
  // The group wins any contention, so a board driver never hides a drive fault.
  // pad level resolution
  always_comb begin
    for (int i = 0; i < NUM_MC; i++) begin
      if (!pin_oe_n_q[i]) begin
        pad[i] = pin_out_q[i];
      end else if (ext_en[i]) begin
        pad[i] = ext_val[i];
      end else begin
        pad[i] = 1'h1;
      end
    end
  end
endmodule : lg_pin_model

/* bench/lg_logic_group_tb.sv */
`timescale 1ns/1ps

module lg_logic_group_tb;
  import lg_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  // Stimulus and design outputs.
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic [NUM_MC-1:0] pin_in, pin_out_q, pin_oe_n_q, route_mc_q, route_node_q, route_pin_q;
  lg_glob_t glob_pins = '0;
  logic [NUM_EXT-1:0] route_ext = '0;
  logic [NUM_IN-1:0][SEL_W-1:0] route_sel;
  logic [NUM_PT-1:0][NUM_IN-1:0] and_true, and_comp;
  logic [NUM_MC-1:0][NUM_PT-1:0] or_sel;
  lg_grp_cfg_t grp_cfg;
  lg_mc_cfg_t [NUM_MC-1:0] mc_cfg;
  logic [NUM_MC-1:0] ext_en = '0;
  logic [NUM_MC-1:0] ext_val = '0;
  int error_cnt = 0;
  int cmp_count = 0;
  // Storage steps: data bits {ce, t, d} and expected outputs of macrocells 10 down to 3.
  localparam logic [2:0] EXT_TAB [5] = '{3'h3, 3'h2, 3'h5, 3'h2, 3'h2};
  localparam logic [7:0] EXP_TAB [5] = '{8'h9b, 8'h2b, 8'hb7, 8'h27, 8'h24};

  // ----------------------------------------------------------------
  // Clock, design and pads
  // ----------------------------------------------------------------
  // Free running 100 MHz clock.
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  lg_logic_group dut (.clk_sys(clk_sys), .nrst(nrst), .pin_in(pin_in), .pin_out_q(pin_out_q),
    .pin_oe_n_q(pin_oe_n_q), .glob_pins(glob_pins), .route_ext(route_ext), .route_mc_q(route_mc_q),
    .route_node_q(route_node_q), .route_pin_q(route_pin_q), .route_sel(route_sel),
    .and_true(and_true), .and_comp(and_comp), .or_sel(or_sel), .grp_cfg(grp_cfg), .mc_cfg(mc_cfg));

  lg_pin_model pads (.pin_out_q(pin_out_q), .pin_oe_n_q(pin_oe_n_q), .ext_en(ext_en),
    .ext_val(ext_val), .pad(pin_in));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Inputs always move one nanosecond after the rising edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Latency of control terms is not fixed, so poll with a bound before judging.
  task automatic wait_mc(input int idx, input logic val, input string name);
    int n;
    n = 0;
    while (route_mc_q[idx] !== val && n < 8) begin
      cyc(1);
      n++;
    end
    check(name, route_mc_q[idx], val);
  endtask : wait_mc

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude

  // Group inputs 0..31 take the outside routing; 38 feeds back macrocell 0, 39 repeats bit 2.
  task automatic configure();
    for (int i = 0; i < NUM_IN; i++) begin
      route_sel[i] = (i < NUM_EXT) ? SEL_W'(i) : 7'h7f;
    end
    route_sel[38] = 7'h30;
    route_sel[39] = 7'h02;
    and_true = '0;
    and_comp = '0;
    or_sel = '0;
    grp_cfg = '0;
    mc_cfg = '0;
    for (int k = 0; k < 8; k++) begin
      and_true[k][k] = 1'h1;
    end
    and_true[8] = 40'h00_0000_0003;
    and_true[54][38] = 1'h1;
    and_true[55][39] = 1'h1;
    grp_cfg.ct_clk_pt = 6'h06;
    grp_cfg.ct_rst_pt = 6'h05;
    or_sel[0][8] = 1'h1;
    mc_cfg[0].pad_mode = PAD_TRI;
    mc_cfg[0].oe_src = OE_LOCAL;
    mc_cfg[0].oe_pt = 6'h03;
    or_sel[1][8] = 1'h1;
    or_sel[1][55] = 1'h1;
    mc_cfg[1].invert = 1'h1;
    or_sel[2][8] = 1'h1;
    mc_cfg[2].xor_en = 1'h1;
    mc_cfg[2].xor_pt = 6'h01;
    mc_cfg[2].pad_mode = PAD_OD;
    for (int m = 3; m < 12; m++) begin
      mc_cfg[m].mode = MODE_DFF;
      or_sel[m][0] = (m != 4 && m != 9);
    end
    or_sel[4][1] = 1'h1;
    mc_cfg[4].mode = MODE_TFF;
    mc_cfg[5].ce_en = 1'h1;
    mc_cfg[5].ce_pt = 6'h02;
    mc_cfg[6].input_reg = 1'h1;
    mc_cfg[7].both_edge = 1'h1;
    mc_cfg[8].clk_fall = 1'h1;
    mc_cfg[8].invert = 1'h1;
    mc_cfg[9].set_src = SR_LOCAL;
    mc_cfg[9].set_pt = 6'h04;
    mc_cfg[9].rst_src = SR_GLOBAL;
    mc_cfg[10].mode = MODE_LATCH;
    mc_cfg[11].clk_src = CLK_GROUP;
    mc_cfg[11].rst_src = SR_GROUP;
    or_sel[12][54] = 1'h1;
    and_comp[9][0] = 1'h1;
    or_sel[13][9] = 1'h1;
    mc_cfg[13].pad_mode = PAD_TRI;
    mc_cfg[13].oe_src = OE_GTS0;
    grp_cfg.ct_oe_pt = 6'h07;
    mc_cfg[14].pad_mode = PAD_TRI;
    mc_cfg[14].oe_src = OE_GROUP;
    grp_cfg.ct_set_pt = 6'h04;
    mc_cfg[15].mode = MODE_DFF;
    mc_cfg[15].clk_src = CLK_LOCAL;
    mc_cfg[15].clk_pt = 6'h07;
    mc_cfg[15].set_src = SR_GROUP;
    or_sel[15][0] = 1'h1;
    ext_en[6] = 1'h1;
  endtask : configure

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check("reset_oe_n", pin_oe_n_q, 16'hffff);
    check("reset_route", route_mc_q, 16'h0000);
  endtask : t_reset

  // Every input combination through shared terms, polarity, XOR and the three pad kinds.
  task automatic t_comb();
    logic a, b, c, e0, e1, e2;
    for (int v = 0; v < 8; v++) begin
      {c, b, a} = v[2:0];
      route_ext[3:0] = {c, c, b, a};
      e0 = a & b;
      e1 = ~(e0 | c);
      e2 = e0 ^ b;
      cyc(1);
      check("comb_and", route_mc_q[0], e0);
      check("comb_shared_inv", route_mc_q[1], e1);
      check("comb_xor", route_mc_q[2], e2);
      check("pad_push", {pin_oe_n_q[1], pin_out_q[1]}, {1'h0, e1});
      check("pad_open_drain", {pin_oe_n_q[2], pin_out_q[2]}, {e2, 1'h0});
      check("pad_local_oe", pin_oe_n_q[0], !c);
      cyc(1);
      check("feedback", route_mc_q[12], e0);
    end
  endtask : t_comb

  // Alternating clock edges against D, T, enabled D, input register, both-edge, falling and latch.
  task automatic t_storage();
    for (int i = 0; i < 5; i++) begin
      route_ext[2:0] = EXT_TAB[i];
      ext_val[6] = (i == 0);
      cyc(4);
      glob_pins.gck[0] = ~glob_pins.gck[0];
      cyc(5);
      check("d_flop", route_mc_q[3], EXP_TAB[i][0]);
      check("t_flop", route_mc_q[4], EXP_TAB[i][1]);
      check("clock_enable", route_mc_q[5], EXP_TAB[i][2]);
      check("input_reg", route_mc_q[6], EXP_TAB[i][3]);
      check("both_edge", route_mc_q[7], EXP_TAB[i][4]);
      check("falling_edge", route_mc_q[8], EXP_TAB[i][5]);
      check("latch", route_mc_q[10], EXP_TAB[i][7]);
      check("buried_node", route_node_q[6], EXT_TAB[i][0]);
      check("pin_feedback", route_pin_q[6], EXP_TAB[0][3] & (i == 0));
    end
  endtask : t_storage

  // Group clock and reset terms, local set and global reset.
  task automatic t_control();
    route_ext[0] = 1'h1;
    route_ext[6] = 1'h1;
    wait_mc(11, 1'h1, "group_clock");
    route_ext[5] = 1'h1;
    wait_mc(11, 1'h0, "group_reset");
    route_ext[6] = 1'h0;
    cyc(2);
    route_ext[6] = 1'h1;
    cyc(6);
    check("reset_beats_clock", route_mc_q[11], 1'h0);
    route_ext[5] = 1'h0;
    route_ext[4] = 1'h1;
    wait_mc(9, 1'h1, "local_set");
    route_ext[4] = 1'h0;
    glob_pins.gsr = 1'h1;
    wait_mc(9, 1'h0, "global_reset");
    glob_pins.gsr = 1'h0;
  endtask : t_control

  // Complemented literal, global and group enables, local clock and group set.
  task automatic t_sources();
    route_ext[0] = 1'h0;
    route_ext[7] = 1'h1;
    glob_pins.gts[0] = 1'h1;
    cyc(4);
    check("complement_term", route_mc_q[13], 1'h1);
    check("global_oe", pin_oe_n_q[13], 1'h0);
    check("group_oe", pin_oe_n_q[14], 1'h0);
    check("local_clock", route_mc_q[15], 1'h0);
    route_ext[0] = 1'h1;
    route_ext[7] = 1'h0;
    glob_pins.gts[0] = 1'h0;
    cyc(4);
    check("complement_off", route_mc_q[13], 1'h0);
    check("global_oe_off", pin_oe_n_q[13], 1'h1);
    check("group_oe_off", pin_oe_n_q[14], 1'h1);
    check("local_fall_held", route_mc_q[15], 1'h0);
    route_ext[4] = 1'h1;
    cyc(3);
    check("group_set", route_mc_q[15], 1'h1);
    route_ext[4] = 1'h0;
  endtask : t_sources

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    configure();
    cyc(20);
    t_reset();
    nrst = 1'h1;
    cyc(2);
    t_comb();
    t_storage();
    t_control();
    t_sources();
    conclude();
  end

  // The run needs about one microsecond, so this only fires on a hang.
  initial begin
    #50us;
    error_cnt++;
    $display("watchdog expired");
    conclude();
  end
endmodule : lg_logic_group_tb
